// *** src/lvb_ctrl.sv ***
// control and configuration logic of the single-phase low-voltage buck
// assumes otp and in-sequence strap settle during reset; standby request is an async pin
module lvb_ctrl
  import lvb_pkg::*;
(
  input wire logic clk_sys, // 100 MHz system clock
  input wire logic sys_rst, // async reset, active high
  input wire lvb_otp_s otp, // one-time-programmable defaults
  input wire logic standby_pin, // standby state request from outside
  input wire logic [3:0] avs_address, // word address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output lvb_stage_s stage, // controls to power stage
  output logic irq_out_n // interrupt, active low
);

  // What this block does
  // - one 5-bit voltage code serves both run and standby states
  // - voltage rewrite while on discharges output, then re-enables at new code
  // - voltage code loads from one-time-programmable bits at power-up
  // - codes 0..27 map to 1.00..4.10 V; codes above 27 give 4.10 V
  // - run mode resets to autoskip if sequenced, else disabled; writable
  // - standby mode resets to autoskip if sequenced, else disabled; writable
  // - mode 00 off, 01 forced PWM, 10 PFM, 11 autoskip
  // - any operating mode change raises the mode-change interrupt unless masked
  // - run/standby switch keeps voltage unless new mode enables or disables
  // - 2-bit peak current limit selects 2.1, 2.6, 3.0 or 4.5 A
  // - 3-bit phase field defaults to 0 degrees and stays writable
  // - phase codes 000..110 give 45..315 degrees, 111 gives 0 degrees
  // - 2-bit otp inductor select: 1.0, 0.47, 1.5 uH, 11 reserved

  function automatic logic [15:0] lvb_code_mv(input logic [4:0] code);
    logic [15:0] mv;
    mv = 16'h0;
    case (code)
      5'h00: mv = 16'h03E8;
      5'h01: mv = 16'h044C;
      5'h02: mv = 16'h04B0;
      5'h03: mv = 16'h04E2;
      5'h04: mv = 16'h0514;
      5'h05: mv = 16'h0546;
      5'h06: mv = 16'h05DC;
      5'h07: mv = 16'h0640;
      5'h08: mv = 16'h0708;
      5'h09: mv = 16'h073A;
      5'h0A: mv = 16'h07D0;
      5'h0B: mv = 16'h0834;
      5'h0C: mv = 16'h0866;
      5'h0D: mv = 16'h08CA;
      5'h0E: mv = 16'h08FC;
      5'h0F: mv = 16'h0960;
      5'h10: mv = 16'h09C4;
      5'h11: mv = 16'h0AF0;
      5'h12: mv = 16'h0C4E;
      5'h13: mv = 16'h0C80;
      5'h14: mv = 16'h0CB2;
      5'h15: mv = 16'h0CE4;
      5'h16: mv = 16'h0D16;
      5'h17: mv = 16'h0D48;
      5'h18: mv = 16'h0DAC;
      5'h19: mv = 16'h0ED8;
      5'h1A: mv = 16'h0FA0;
      default: mv = 16'h1004;
    endcase
    return mv;
  endfunction

  localparam logic [9:0] DISCH_CNT = 10'(LVB_DISCH_CYC);

  logic [4:0] vout_r;
  logic [1:0] run_op_r;
  logic [1:0] stby_op_r;
  logic [1:0] ilim_r;
  logic [2:0] phase_r;
  logic [1:0] lsel_r;
  logic irq_flag_r;
  logic irq_mask_r;
  logic boot_r;
  logic stby_m_r;
  logic stby_r;
  logic [1:0] op_r;
  logic [1:0] op_nxt;
  lvb_seq_e seq_r;
  logic [9:0] dis_cnt_r;
  logic wr_ack_r;
  logic rd_ack_r;
  logic vout_wr;
  logic mode_change;
  logic [31:0] rd_data;

  wire logic acc = avs_read | avs_write;
  // a write lands on the answering edge, the one at which the master sees waitrequest low
  wire logic wr_go = avs_write & wr_ack_r;
  wire logic sel_vout = wr_go & (avs_address == LVB_ADDR_VOUT) & avs_byteenable[0];
  wire logic sel_mode = wr_go & (avs_address == LVB_ADDR_MODE) & avs_byteenable[0];
  wire logic sel_cfg = wr_go & (avs_address == LVB_ADDR_CFG) & avs_byteenable[0];
  wire logic sel_irq = wr_go & (avs_address == LVB_ADDR_IRQ) & avs_byteenable[0];
  wire logic sel_mask = wr_go & (avs_address == LVB_ADDR_MASK) & avs_byteenable[0];

  // one wait cycle per access: request taken on the edge after it rises, answered next
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ack_r <= 1'b0;
      rd_ack_r <= 1'b0;
    end else begin
      wr_ack_r <= avs_write & ~wr_ack_r;
      rd_ack_r <= avs_read & ~rd_ack_r;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(acc & ~wr_ack_r & ~rd_ack_r);
    end
  end

  // two-flop sync of the asynchronous standby request
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stby_m_r <= 1'b0;
      stby_r <= 1'b0;
    end else begin
      stby_m_r <= standby_pin;
      stby_r <= stby_m_r;
    end
  end

  // otp straps are caught on the first edge after reset release, not under reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      vout_r <= 5'h0;
    end else if (boot_r) begin
      vout_r <= otp.vout_code;
    end else if (sel_vout) begin
      vout_r <= avs_writedata[4:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_op_r <= LVB_OP_OFF;
      stby_op_r <= LVB_OP_OFF;
    end else if (boot_r) begin
      run_op_r <= otp.in_seq ? LVB_OP_AUTO : LVB_OP_OFF;
      stby_op_r <= otp.in_seq ? LVB_OP_AUTO : LVB_OP_OFF;
    end else if (sel_mode) begin
      run_op_r <= avs_writedata[LVB_MODE_RUN_LSB +: 2];
      stby_op_r <= avs_writedata[LVB_MODE_STBY_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ilim_r <= LVB_ILIM_RST;
      phase_r <= LVB_PHASE_RST;
    end else if (sel_cfg) begin
      ilim_r <= avs_writedata[LVB_CFG_ILIM_LSB +: 2];
      phase_r <= avs_writedata[LVB_CFG_PHASE_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lsel_r <= 2'h0;
    end else if (boot_r) begin
      lsel_r <= otp.lsel;
    end
  end

  always_comb begin
    op_nxt = stby_r ? stby_op_r : run_op_r;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      op_r <= LVB_OP_OFF;
    end else begin
      op_r <= op_nxt;
    end
  end

  assign mode_change = ~boot_r & (op_r != op_nxt);
  assign vout_wr = sel_vout & (avs_writedata[4:0] != vout_r);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      seq_r <= LVB_ST_OFF;
      dis_cnt_r <= 10'h0;
    end else begin
      case (seq_r)
        LVB_ST_OFF: begin
          if (op_r != LVB_OP_OFF) begin
            seq_r <= LVB_ST_ON;
          end
        end
        LVB_ST_ON: begin
          if (op_r == LVB_OP_OFF) begin
            seq_r <= LVB_ST_OFF;
          end else if (vout_wr) begin
            seq_r <= LVB_ST_DIS;
            dis_cnt_r <= DISCH_CNT - 10'h1;
          end
        end
        LVB_ST_DIS: begin
          if (dis_cnt_r == 10'h0) begin
            seq_r <= LVB_ST_OFF;
          end else begin
            dis_cnt_r <= dis_cnt_r - 10'h1;
          end
        end
        default: seq_r <= LVB_ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stage <= '0;
    end else begin
      stage.enable <= (seq_r == LVB_ST_ON) & (op_r != LVB_OP_OFF);
      stage.discharge <= (seq_r != LVB_ST_ON);
      stage.op <= (seq_r == LVB_ST_ON) ? op_r : LVB_OP_OFF;
      stage.vout_code <= vout_r;
      stage.peak_limit <= ilim_r;
      stage.phase <= phase_r;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_flag_r <= 1'b0;
    end else if (mode_change) begin
      irq_flag_r <= 1'b1;
    end else if (sel_irq & avs_writedata[0]) begin
      irq_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_r <= 1'b0;
    end else if (sel_mask) begin
      irq_mask_r <= avs_writedata[0];
    end
  end

  // output follows flag one cycle later; mask bit set means source blocked
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~(irq_flag_r & ~irq_mask_r);
    end
  end

  always_comb begin
    rd_data = LVB_UNMAPPED;
    case (avs_address)
      LVB_ADDR_VOUT: rd_data[4:0] = vout_r;
      LVB_ADDR_MODE: begin
        rd_data[LVB_MODE_RUN_LSB +: 2] = run_op_r;
        rd_data[LVB_MODE_STBY_LSB +: 2] = stby_op_r;
      end
      LVB_ADDR_CFG: begin
        rd_data[LVB_CFG_ILIM_LSB +: 2] = ilim_r;
        rd_data[LVB_CFG_PHASE_LSB +: 3] = phase_r;
      end
      LVB_ADDR_STAT: begin
        rd_data[LVB_STAT_STBY_BIT] = stby_r;
        rd_data[LVB_STAT_DIS_BIT] = (seq_r == LVB_ST_DIS);
        rd_data[LVB_STAT_OP_LSB +: 2] = op_r;
        rd_data[LVB_STAT_LSEL_LSB +: 2] = lsel_r;
        rd_data[LVB_STAT_MV_LSB +: 16] = lvb_code_mv(vout_r);
      end
      LVB_ADDR_IRQ: rd_data[0] = irq_flag_r;
      LVB_ADDR_MASK: rd_data[0] = irq_mask_r;
      default: rd_data = LVB_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read & ~rd_ack_r) begin
      avs_readdata <= rd_data;
    end
  end

endmodule // lvb_ctrl

// *** src/lvb_pkg.sv ***
// package for the low-voltage buck control block: register map, fields, reset values, timing
// assumes a single 100 MHz clock domain and an Avalon-MM slave with 32-bit data
package lvb_pkg;
  // register word addresses
  localparam logic [3:0] LVB_ADDR_VOUT = 4'h0;
  localparam logic [3:0] LVB_ADDR_MODE = 4'h1;
  localparam logic [3:0] LVB_ADDR_CFG = 4'h2;
  localparam logic [3:0] LVB_ADDR_STAT = 4'h3;
  localparam logic [3:0] LVB_ADDR_IRQ = 4'h4;
  localparam logic [3:0] LVB_ADDR_MASK = 4'h5;
  localparam int LVB_ADDR_LSB = 2;
  // field positions
  localparam int LVB_MODE_RUN_LSB = 0;
  localparam int LVB_MODE_STBY_LSB = 2;
  localparam int LVB_CFG_ILIM_LSB = 0;
  localparam int LVB_CFG_PHASE_LSB = 4;
  localparam int LVB_STAT_STBY_BIT = 0;
  localparam int LVB_STAT_DIS_BIT = 1;
  localparam int LVB_STAT_OP_LSB = 4;
  localparam int LVB_STAT_LSEL_LSB = 8;
  localparam int LVB_STAT_MV_LSB = 16;
  // operating modes
  localparam logic [1:0] LVB_OP_OFF = 2'h0;
  localparam logic [1:0] LVB_OP_PWM = 2'h1;
  localparam logic [1:0] LVB_OP_PFM = 2'h2;
  localparam logic [1:0] LVB_OP_AUTO = 2'h3;
  // reset values, top voltage code and unmapped read value
  localparam logic [2:0] LVB_PHASE_RST = 3'h7;
  localparam logic [1:0] LVB_ILIM_RST = 2'h0;
  localparam logic [4:0] LVB_VOUT_TOP = 5'h1B;
  localparam logic [31:0] LVB_UNMAPPED = 32'h0;
  // discharge time before re-enable at a new voltage
  localparam int LVB_DISCH_US = 10;
  localparam int LVB_CLK_MHZ = 100;
  localparam int LVB_DISCH_CYC = LVB_DISCH_US * LVB_CLK_MHZ;

  typedef enum logic [2:0] {
    LVB_ST_OFF = 3'b001,
    LVB_ST_ON = 3'b010,
    LVB_ST_DIS = 3'b100
  } lvb_seq_e;

  typedef struct packed {
    logic [4:0] vout_code;
    logic [1:0] run_op;
    logic [1:0] stby_op;
    logic [1:0] lsel;
    logic in_seq;
  } lvb_otp_s;

  typedef struct packed {
    logic enable;
    logic discharge;
    logic [1:0] op;
    logic [4:0] vout_code;
    logic [1:0] peak_limit;
    logic [2:0] phase;
  } lvb_stage_s;
endpackage

// *** sim/lvb_ctrl_monitor.sv ***
// assertions on the ports of lvb_ctrl
// assumes one clock domain; bound from the bench top
module lvb_ctrl_monitor
  import lvb_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // reset
  input wire lvb_otp_s otp, // defaults
  input wire logic standby_pin, // standby
  input wire logic [3:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_writedata, // wdata
  input wire logic [3:0] avs_byteenable, // lanes
  input wire logic [31:0] avs_readdata, // rdata
  input wire logic avs_waitrequest, // stall
  input wire lvb_stage_s stage, // stage
  input wire logic irq_out_n // irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mask_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // mirror of the mask bit, updated on the accepting edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= 1'h0;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                 && avs_address == LVB_ADDR_MASK) begin
      mask_r <= avs_writedata[0];
    end
  end
  property p_irq_hold;
    !irq_out_n && !avs_write && !$past(avs_write) |=> !irq_out_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq released without a write");
  property p_disch_off;
    stage.discharge |-> !stage.enable;
  endproperty
  a_disch_off: assert property (p_disch_off)
    else $error("enabled while discharging");
  property p_disch_len;
    $rose(stage.discharge) && $past(stage.enable) |-> stage.discharge [*8];
  endproperty
  a_disch_len: assert property (p_disch_len)
    else $error("discharge too short");
  property p_reenable;
    $fell(stage.discharge) && stage.op != LVB_OP_OFF |-> ##[1:4] stage.enable;
  endproperty
  a_reenable: assert property (p_reenable)
    else $error("no re-enable after discharge");
  property p_vout_hold;
    stage.enable && $past(stage.enable) |-> $stable(stage.vout_code);
  endproperty
  a_vout_hold: assert property (p_vout_hold)
    else $error("code moved while enabled");
  property p_irq_set;
    $changed(stage.op) && !mask_r && !$past(sys_rst, 2) && !$past(sys_rst, 3)
      |-> ##[1:2] !irq_out_n;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("mode change not signalled");
  property p_irq_mask;
    mask_r && $past(mask_r) |-> irq_out_n;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("masked irq asserted");
  property p_phase_rst;
    $past(sys_rst, 2) && !$past(sys_rst) |-> stage.phase == LVB_PHASE_RST;
  endproperty
  a_phase_rst: assert property (p_phase_rst)
    else $error("phase not zero degrees after reset");
  c_disch: cover property ($rose(stage.discharge));
  c_irq: cover property ($fell(irq_out_n));
  c_stby: cover property ($rose(standby_pin));
endmodule // lvb_ctrl_monitor

// *** sim/lvb_stage_model.sv ***
// behavioural power stage: flags a level step while switching
// assumes registered stage controls on clk_sys
module lvb_stage_model
  import lvb_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // reset
  input wire lvb_stage_s stage, // controls
  output logic bad_step // code moved while on
);
  timeunit 1ns;
  timeprecision 1ps;
  lvb_stage_s prev_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prev_r <= '0;
      bad_step <= 1'h0;
    end else begin
      prev_r <= stage;
      if (prev_r.enable && stage.enable && prev_r.vout_code != stage.vout_code) begin
        bad_step <= 1'h1;
      end
    end
  end
endmodule // lvb_stage_model

// *** sim/test_lvb_ctrl.sv ***
// self-checking bench for lvb_ctrl
// assumes one wait cycle per access and a 1000-cycle discharge
module test_lvb_ctrl;
  import lvb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, sys_rst, standby_pin, avs_read, avs_write;
  logic avs_waitrequest, irq_out_n, bad_step;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  lvb_otp_s otp;
  lvb_stage_s stage;
  int miscompares, n_checks;
  int mv[28] = '{1000, 1100, 1200, 1250, 1300, 1350, 1500, 1600, 1800, 1850, 2000, 2100,
    2150, 2250, 2300, 2400, 2500, 2800, 3150, 3200, 3250, 3300, 3350, 3400, 3500, 3800,
    4000, 4100};
  lvb_ctrl u_dut (.clk_sys, .sys_rst, .otp, .standby_pin, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .stage, .irq_out_n);
  lvb_stage_model u_model (.clk_sys, .sys_rst, .stage, .bad_step);
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one edge after release keeps strobes from being driven twice in a step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0) begin
      n++;
      if (n > 20) begin
        miscompares++;
        test_done();
      end
      @(posedge clk_sys);
    end
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic t_boot();
    logic [31:0] q;
    bus(1'h0, LVB_ADDR_VOUT, 32'h0, q);
    chk("vout", 32'h8, q);
    bus(1'h0, LVB_ADDR_MODE, 32'h0, q);
    chk("mode", 32'hF, q);
    bus(1'h0, LVB_ADDR_CFG, 32'h0, q);
    chk("phase", 32'h7, 32'(q[6:4]));
    bus(1'h0, LVB_ADDR_STAT, 32'h0, q);
    chk("lsel", 32'h2, 32'(q[9:8]));
    chk("op", 32'h3, 32'(q[5:4]));
    bus(1'h0, 4'hF, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("t_boot done");
  endtask
  task automatic t_vout();
    logic [31:0] q;
    for (int i = 0; i < 32; i++) begin
      bus(1'h1, LVB_ADDR_VOUT, 32'(i), q);
      bus(1'h0, LVB_ADDR_STAT, 32'h0, q);
      chk("mv", 32'(i > 27 ? 4100 : mv[i]), 32'(q[31:16]));
      chk("disch", 32'h1, 32'(q[1]));
      repeat (1010) @(posedge clk_sys);
      chk("enable", 32'h1, 32'(stage.enable));
      chk("code", 32'(i), 32'(stage.vout_code));
    end
    $display("t_vout done");
  endtask
  task automatic t_mode();
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, LVB_ADDR_MODE, 32'((3 - i) << 2 | i), q);
      repeat (3) @(posedge clk_sys);
      chk("run op", 32'(i), 32'(stage.op));
      chk("irq", 32'h0, 32'(irq_out_n));
      bus(1'h1, LVB_ADDR_IRQ, 32'h1, q);
      repeat (2) @(posedge clk_sys);
      chk("irq clr", 32'h1, 32'(irq_out_n));
      standby_pin <= 1'h1;
      repeat (6) @(posedge clk_sys);
      chk("stby op", 32'(3 - i), 32'(stage.op));
      chk("stby code", 32'h1F, 32'(stage.vout_code));
      chk("stby irq", 32'h0, 32'(irq_out_n));
      standby_pin <= 1'h0;
      repeat (6) @(posedge clk_sys);
      bus(1'h1, LVB_ADDR_IRQ, 32'h1, q);
    end
    $display("t_mode done");
  endtask
  task automatic t_mask();
    logic [31:0] q;
    bus(1'h1, LVB_ADDR_MASK, 32'h1, q);
    bus(1'h1, LVB_ADDR_MODE, 32'h1, q);
    repeat (4) @(posedge clk_sys);
    chk("masked", 32'h1, 32'(irq_out_n));
    bus(1'h0, LVB_ADDR_IRQ, 32'h0, q);
    chk("flag", 32'h1, 32'(q[0]));
    bus(1'h1, LVB_ADDR_MASK, 32'h0, q);
    repeat (2) @(posedge clk_sys);
    chk("unmasked", 32'h0, 32'(irq_out_n));
    bus(1'h1, LVB_ADDR_IRQ, 32'h1, q);
    repeat (2) @(posedge clk_sys);
    chk("cleared", 32'h1, 32'(irq_out_n));
    $display("t_mask done");
  endtask
  task automatic t_cfg();
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      bus(1'h1, LVB_ADDR_CFG, 32'(i << 4 | i % 4), q);
      repeat (2) @(posedge clk_sys);
      chk("limit", 32'(i % 4), 32'(stage.peak_limit));
      chk("phase", 32'(i), 32'(stage.phase));
    end
    $display("t_cfg done");
  endtask
  initial begin
    sys_rst = 1'h1;
    standby_pin = 1'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    otp = {5'h08, 2'h0, 2'h0, 2'h2, 1'h1};
    miscompares = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    t_boot();
    t_vout();
    t_mode();
    t_mask();
    t_cfg();
    chk("step", 32'h0, 32'(bad_step));
    test_done();
  end
endmodule // test_lvb_ctrl
bind lvb_ctrl lvb_ctrl_monitor u_mon (.clk_sys, .sys_rst, .otp, .standby_pin, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .stage, .irq_out_n);
